// ### verilog/prot_check_pkg.sv
// Constants, types and helpers of the page access protection checker
// Functional notes
// - Shadow-stack pages exist only while shadow_stack_enable is set.
// - Shadow-stack page: final entry read-only and dirty, all upper levels writable.
// - Shadow-stack access at privilege 0-2 is supervisor, at privilege 3 user.
// - user_shadow_store_op accesses are always user shadow-stack accesses.
// - Shadow-stack page user bit 0 means supervisor page, 1 means user page.
// - Matching-class shadow-stack access may read or write, despite read-only final entry.
// - Ordinary reads of shadow-stack pages pass, subject to the user/supervisor check.
// - Reject cross-class shadow-stack accesses and shadow-stack accesses to ordinary pages.
// - Ordinary writes to a shadow-stack page are rejected.
// - Rejection raises page_fault with user/write violation flags and shadow-stack flag.
// - Write-protect clear: any supervisor level makes page supervisor, writable by supervisor.
// - User page needs all levels user; writable only if all levels writable.
// - Write-protect set: supervisor page read-only if any level is read-only.
// - Write-protect set faults supervisor writes to read-only user pages; clear permits.
// - Segment checks come first; page checks are skipped on a segment violation.
// - Any violation blocks the access; segment gives protection or stack fault.
// - upper_tag_ignore_enable acts only with long mode and a 64-bit code segment.
// - Tagging with 4-level paging: data/extra references check only bits 56:48.
// - Tagging with 5-level paging: data/extra references get no canonical check.
// - Code, stack, thread-base and system-table references keep the full check.
// - Tagging makes breakpoint matching ignore bits 63:57, compare bits 56:0.
// - Privilege-3 access to a supervisor page raises page_fault.
package prot_check_pkg;

  localparam int ADDR_W = 8;
  localparam int VA_W = 64;
  localparam int PA_W = 52;
  localparam int LVLS = 5;
  localparam int NUM_BP = 4;

  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_FAULTS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_BP_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_BP_LAST = 8'h2c;

  localparam int CTRL_SSE_BIT = 0;
  localparam int CTRL_WP_BIT = 1;
  localparam int CTRL_LMA_BIT = 2;
  localparam int CTRL_CS64_BIT = 3;
  localparam int CTRL_LVL5_BIT = 4;
  localparam int CTRL_UAIE_BIT = 20;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] BP_RESET = 32'h0000_0000;
  localparam logic [15:0] FAULTS_RESET = 16'h0000;

  localparam int SIGN4_BIT = 47;
  localparam int SIGN5_BIT = 56;
  localparam int TAG_LO_BIT = 57;
  localparam logic [1:0] PRIV_USER = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ACC_FETCH, ACC_READ, ACC_WRITE, ACC_SS_READ, ACC_SS_WRITE
  } acc_type_e;

  typedef enum logic [2:0] {
    SEG_DATA, SEG_EXTRA, SEG_CODE, SEG_STACK, SEG_TBASE_A, SEG_TBASE_B,
    SEG_SYSTABLE
  } seg_e;

  typedef struct packed {
    acc_type_e acc_type;
    logic user_shadow_store_op;
    logic [1:0] current_privilege_level;
    seg_e seg;
    logic seg_violation;
    logic seg_is_stack;
    logic [VA_W-1:0] lin_addr;
    logic [PA_W-1:0] phys_addr;
    logic [LVLS-1:0] walk_used;
    logic [LVLS-1:0] walk_user;
    logic [LVLS-1:0] walk_write;
    logic final_dirty;
  } req_s;

  typedef struct packed {
    logic permit;
    logic page_fault;
    logic general_protection_fault;
    logic stack_fault;
    logic err_user_viol;
    logic err_write_viol;
    logic err_shadow;
    logic [NUM_BP-1:0] bp_hit;
    logic [PA_W-1:0] phys_addr;
  } resp_s;

  // True when bits hi..lo+1 of a all equal bit lo
  function automatic logic span_equal(input logic [VA_W-1:0] a,
                                      input int lo, input int hi);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < VA_W; i++)
    begin
      if (i > lo && i <= hi && a[i] != a[lo])
      begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : span_equal

endpackage : prot_check_pkg

// ### verilog/page_access_protection_check.sv
// Protection check of translated accesses with an AXI4-Lite control port
//
// The AXI4-Lite register port and the address map were left to the implementer.
module page_access_protection_check
  import prot_check_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire prot_check_pkg::req_s req,
  output logic resp_valid,
  output prot_check_pkg::resp_s resp,
  input wire logic [prot_check_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [prot_check_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import prot_check_pkg::*;

  // Register map: ctrl, fault counter, breakpoint words (low, high)
  logic [31:0] ctrl_q;
  logic [15:0] faults_q;
  logic [31:0] bp_word_q [2*NUM_BP];

  function automatic logic is_bp_addr(input logic [ADDR_W-1:0] a);
    return a >= OFF_BP_BASE && a <= OFF_BP_LAST && a[1:0] == 2'h0;
  endfunction : is_bp_addr

  function automatic logic [2:0] bp_index(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - OFF_BP_BASE;
    return d[4:2];
  endfunction : bp_index

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        r[8*b +: 8] = data[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // Control bits
  wire sse = ctrl_q[CTRL_SSE_BIT];
  wire wp = ctrl_q[CTRL_WP_BIT];
  wire lma = ctrl_q[CTRL_LMA_BIT];
  wire cs64 = ctrl_q[CTRL_CS64_BIT];
  wire lvl5 = ctrl_q[CTRL_LVL5_BIT];
  wire uaie = ctrl_q[CTRL_UAIE_BIT];
  wire tag_active = uaie & lma & cs64;

  // Access classification
  wire accept = req_valid & req_ready;
  wire is_ss = req.acc_type == ACC_SS_READ || req.acc_type == ACC_SS_WRITE;
  wire is_write = req.acc_type == ACC_WRITE || req.acc_type == ACC_SS_WRITE;
  wire is_data = req.acc_type != ACC_FETCH;
  wire cpl_user = req.current_privilege_level == PRIV_USER;
  wire ss_user_acc = req.user_shadow_store_op | cpl_user;

  // Unused levels (short walks) count as user and writable
  wire [LVLS-1:0] lvl_user = req.walk_user | ~req.walk_used;
  wire [LVLS-1:0] lvl_write = req.walk_write | ~req.walk_used;
  wire page_user = &lvl_user;
  wire page_writable = &lvl_write;
  wire ss_page = sse & ~lvl_write[0] & req.final_dirty &
                 (&lvl_write[LVLS-1:1]);
  wire ss_class_match = ss_user_acc == page_user;

  // Canonical check, relaxed for tagged data/extra references
  wire de_seg = req.seg == SEG_DATA || req.seg == SEG_EXTRA;
  wire relax = tag_active & de_seg;
  wire canon4_full = span_equal(req.lin_addr, SIGN4_BIT, VA_W - 1);
  wire canon4_tag = span_equal(req.lin_addr, SIGN4_BIT, TAG_LO_BIT - 1);
  wire canon5_full = span_equal(req.lin_addr, SIGN5_BIT, VA_W - 1);
  wire canon_ok = lvl5 ? (relax | canon5_full)
                       : (relax ? canon4_tag : canon4_full);

  // Segment stage, evaluated first
  wire seg_fail = req.seg_violation | ~canon_ok;
  wire seg_stack = req.seg_is_stack | req.seg == SEG_STACK;

  // Page stage for ordinary accesses
  wire nss_us_viol = cpl_user & ~page_user;
  wire nss_ro_viol = ~page_writable & (cpl_user | wp);
  wire nss_rw_viol = is_write & (ss_page | nss_ro_viol);

  // Page stage for shadow-stack accesses
  wire ss_us_viol = ss_page & ~ss_class_match;
  wire ss_rw_viol = ~ss_page;

  wire pg_us_viol = is_ss ? ss_us_viol : nss_us_viol;
  wire pg_rw_viol = is_ss ? ss_rw_viol : nss_rw_viol;
  wire pg_fail = pg_us_viol | pg_rw_viol;

  // Data breakpoint match, tag bits ignored while tagging is active
  logic [NUM_BP-1:0] bp_match;
  genvar g;
  generate
    for (g = 0; g < NUM_BP; g++)
    begin : g_bp
      wire [VA_W-1:0] bp_addr = {bp_word_q[2*g+1], bp_word_q[2*g]};
      wire hi_eq = bp_addr[VA_W-1:TAG_LO_BIT] ==
                   req.lin_addr[VA_W-1:TAG_LO_BIT];
      wire lo_eq = bp_addr[TAG_LO_BIT-1:0] ==
                   req.lin_addr[TAG_LO_BIT-1:0];
      assign bp_match[g] = is_data & lo_eq & (hi_eq | tag_active);
    end
  endgenerate

  // Decision assembled with the translation result
  resp_s resp_d;
  always_comb
  begin
    resp_d = '0;
    resp_d.phys_addr = req.phys_addr;
    resp_d.bp_hit = bp_match;
    if (seg_fail)
    begin
      resp_d.general_protection_fault = ~seg_stack;
      resp_d.stack_fault = seg_stack;
    end
    else if (pg_fail)
    begin
      resp_d.page_fault = 1'b1;
      resp_d.err_user_viol = pg_us_viol;
      resp_d.err_write_viol = pg_rw_viol;
      resp_d.err_shadow = is_ss;
    end
    else
    begin
      resp_d.permit = 1'b1;
    end
  end

  // One decision per access; the requester holds its request meanwhile
  assign req_ready = ~resp_valid;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      resp_valid <= 1'b0;
      resp <= '0;
    end
    else
    begin
      resp_valid <= accept;
      if (accept)
      begin
        resp <= resp_d;
      end
    end
  end

  // AXI4-Lite write path: address and data taken in either order
  logic aw_full_q;
  logic w_full_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  wire do_write = aw_full_q & w_full_q & ~s_axi_bvalid;
  wire wr_ctrl = aw_addr_q == OFF_CTRL;
  wire wr_bp = is_bp_addr(aw_addr_q);
  wire wr_ro = aw_addr_q == OFF_STATUS || aw_addr_q == OFF_FAULTS;
  wire wr_ok = wr_ctrl | wr_bp | wr_ro;
  assign s_axi_awready = ~aw_full_q;
  assign s_axi_wready = ~w_full_q;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      ctrl_q <= CTRL_RESET;
      for (int i = 0; i < 2 * NUM_BP; i++)
      begin
        bp_word_q[i] <= BP_RESET;
      end
    end
    else if (do_write)
    begin
      if (wr_ctrl)
      begin
        ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q);
      end
      if (wr_bp)
      begin
        bp_word_q[bp_index(aw_addr_q)] <=
          merge(bp_word_q[bp_index(aw_addr_q)], w_data_q, w_strb_q);
      end
    end
  end

  // Saturating count of rejected accesses
  wire fault_event = accept & ~resp_d.permit;
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      faults_q <= FAULTS_RESET;
    end
    else if (fault_event && faults_q != 16'hffff)
    begin
      faults_q <= faults_q + 16'h0001;
    end
  end

  // AXI4-Lite read path
  wire rd_bp = is_bp_addr(s_axi_araddr);
  logic [31:0] rd_word;
  logic rd_ok;
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    if (s_axi_araddr == OFF_CTRL)
    begin
      rd_word = ctrl_q;
    end
    else if (s_axi_araddr == OFF_STATUS)
    begin
      rd_word = {30'h0000_0000, resp_valid, tag_active};
    end
    else if (s_axi_araddr == OFF_FAULTS)
    begin
      rd_word = {16'h0000, faults_q};
    end
    else if (rd_bp)
    begin
      rd_word = bp_word_q[bp_index(s_axi_araddr)];
    end
    else
    begin
      rd_ok = 1'b0;
    end
  end

  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks
  property p_no_ss_pages_when_disabled;
    @(posedge sys_clk) disable iff (!rst_n)
    accept && !sse && is_ss && !seg_fail |=> resp.page_fault && resp.err_shadow;
  endproperty
  a_no_ss_pages_when_disabled: assert property (p_no_ss_pages_when_disabled)
    else $error("shadow access passed with shadow stacks disabled");

  property p_ordinary_write_ss_page;
    @(posedge sys_clk) disable iff (!rst_n)
    accept && ss_page && req.acc_type == ACC_WRITE && !seg_fail
    |=> resp.page_fault && resp.err_write_viol && !resp.err_shadow;
  endproperty
  a_ordinary_write_ss_page: assert property (p_ordinary_write_ss_page)
    else $error("ordinary write to shadow page not rejected");

  property p_ss_match_permits;
    @(posedge sys_clk) disable iff (!rst_n)
    accept && is_ss && ss_page && ss_class_match && !seg_fail |=> resp.permit;
  endproperty
  a_ss_match_permits: assert property (p_ss_match_permits)
    else $error("matching shadow access was refused");

  property p_user_to_supervisor;
    @(posedge sys_clk) disable iff (!rst_n)
    accept && !is_ss && cpl_user && !page_user && !seg_fail
    |=> resp.page_fault && resp.err_user_viol;
  endproperty
  a_user_to_supervisor: assert property (p_user_to_supervisor)
    else $error("user access to supervisor page not faulted");

  property p_wp_user_ro;
    @(posedge sys_clk) disable iff (!rst_n)
    accept && req.acc_type == ACC_WRITE && !cpl_user && page_user &&
    !page_writable && !ss_page && !seg_fail
    |=> resp.page_fault == $past(wp);
  endproperty
  a_wp_user_ro: assert property (p_wp_user_ro)
    else $error("supervisor write to read-only user page mishandled");

  property p_segment_first;
    @(posedge sys_clk) disable iff (!rst_n)
    accept && req.seg_violation
    |=> !resp.page_fault && !resp.permit &&
        (resp.general_protection_fault || resp.stack_fault);
  endproperty
  a_segment_first: assert property (p_segment_first)
    else $error("page check not skipped after segment violation");

  property p_permit_exclusive;
    @(posedge sys_clk) disable iff (!rst_n)
    resp_valid |-> resp.permit ^ (resp.page_fault ||
      resp.general_protection_fault || resp.stack_fault);
  endproperty
  a_permit_exclusive: assert property (p_permit_exclusive)
    else $error("permit and fault not exclusive");

  property p_decision_next;
    @(posedge sys_clk) disable iff (!rst_n)
    accept |=> resp_valid && resp.phys_addr == $past(req.phys_addr) ##1
               !resp_valid;
  endproperty
  a_decision_next: assert property (p_decision_next)
    else $error("decision not returned one cycle after the request");

  property p_tag5_no_canon;
    @(posedge sys_clk) disable iff (!rst_n)
    accept && tag_active && lvl5 && de_seg && !req.seg_violation
    |=> !resp.general_protection_fault && !resp.stack_fault;
  endproperty
  a_tag5_no_canon: assert property (p_tag5_no_canon)
    else $error("canonical fault on tagged 5-level data reference");

  property p_full_canon_kept;
    @(posedge sys_clk) disable iff (!rst_n)
    accept && !lvl5 && !de_seg && !canon4_full
    |=> resp.general_protection_fault || resp.stack_fault;
  endproperty
  a_full_canon_kept: assert property (p_full_canon_kept)
    else $error("non-canonical code or stack reference passed");

endmodule : page_access_protection_check

// ### dv/core_requester.sv
// Requester model standing in for the core's load/store pipeline
module core_requester
  import prot_check_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic go,
  input wire prot_check_pkg::req_s go_req,
  output logic req_valid,
  output prot_check_pkg::req_s req,
  input wire logic req_ready,
  input wire logic resp_valid,
  input wire prot_check_pkg::resp_s resp,
  output logic done,
  output prot_check_pkg::resp_s seen
);
  import prot_check_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic taken_q;

  always_ff @(posedge sys_clk)
  begin
    done <= 1'h0;
    if (!rst_n)
    begin
      req_valid <= 1'h0;
      req <= '0;
      taken_q <= 1'h0;
      seen <= '0;
    end
    // Request stays up with its tags until the decision returns
    else if (req_valid && taken_q && resp_valid)
    begin
      req_valid <= 1'h0;
      req <= ~req;
      taken_q <= 1'h0;
      done <= 1'h1;
      seen <= resp;
    end
    else if (req_valid && req_ready)
      taken_q <= 1'h1;
    else if (go && !req_valid)
    begin
      req_valid <= 1'h1;
      req <= go_req;
    end
  end
endmodule : core_requester

// ### dv/page_access_protection_check_test.sv
// Self-checking bench of the page access protection checker
`define CHK(nm, ex, got) \
  begin checked++; if ((got) !== (ex)) begin err_count++; \
  $display("BAD %s expected %0h seen %0h", nm, ex, got); end end
module page_access_protection_check_test
  import prot_check_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic go = 1'h0;
  logic done, req_valid, req_ready, resp_valid;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  req_s req, nreq = '0;
  resp_s resp, seen;
  logic [31:0] ctrl_q = '0;
  logic [63:0] bp [NUM_BP] = '{default: '0};
  logic [4:0] kuser [5] = '{5'h00, 5'h0f, 5'h1f, 5'h1f, 5'h1b};
  logic [4:0] kwr [5] = '{5'h1e, 5'h1e, 5'h1f, 5'h1d, 5'h1e};
  logic [4:0] kd = 5'h0b;
  logic [63:0] addrs [4] = '{64'h0000_7fff_ffff_f000,
    64'h5a00_0000_1234_5000, 64'h0080_0000_0000_0000,
    64'ha500_0000_0000_0000};
  int err_count = 0, checked = 0, faults = 0;

  always #25 sys_clk = ~sys_clk;

  page_access_protection_check i_page_access_protection_check (
    .sys_clk, .rst_n, .req_valid, .req_ready, .req, .resp_valid, .resp,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  core_requester i_core_requester (
    .sys_clk, .rst_n, .go, .go_req(nreq), .req_valid, .req, .req_ready,
    .resp_valid, .resp, .done, .seen);

  function automatic logic same(logic [63:0] a, int lo, int hi);
    logic s;
    s = 1'h1;
    for (int i = lo; i <= hi; i++)
      s &= (a[i] == a[lo]);
    return s;
  endfunction : same

  // Reference decision for one request under the current control word
  function automatic resp_s model(req_s r);
    resp_s e;
    logic tag, dsx, canon, segf, ss_pg, sup_pg, ss_acc, usr, wr;
    logic [4:0] u, w;
    e = '0;
    tag = ctrl_q[CTRL_UAIE_BIT] & ctrl_q[CTRL_LMA_BIT]
      & ctrl_q[CTRL_CS64_BIT];
    dsx = r.seg inside {SEG_DATA, SEG_EXTRA};
    if (tag && dsx)
      canon = ctrl_q[CTRL_LVL5_BIT] || same(r.lin_addr, SIGN4_BIT, 56);
    else
      canon = same(r.lin_addr, ctrl_q[CTRL_LVL5_BIT] ? 56 : 47, 63);
    segf = r.seg_violation | ~canon;
    u = r.walk_user | ~r.walk_used;
    w = r.walk_write | ~r.walk_used;
    sup_pg = ~&u;
    ss_pg = ctrl_q[CTRL_SSE_BIT] & ~w[0] & r.final_dirty & (&w[4:1]);
    ss_acc = r.acc_type inside {ACC_SS_READ, ACC_SS_WRITE};
    usr = r.current_privilege_level == PRIV_USER;
    wr = r.acc_type inside {ACC_WRITE, ACC_SS_WRITE};
    if (segf)
    begin
      e.stack_fault = r.seg_is_stack | (r.seg == SEG_STACK);
      e.general_protection_fault = ~e.stack_fault;
    end
    else if (ss_acc)
    begin
      e.err_write_viol = ~ss_pg;
      e.err_user_viol = ss_pg & ((usr | r.user_shadow_store_op) == sup_pg);
    end
    else
    begin
      e.err_user_viol = usr & sup_pg;
      e.err_write_viol = wr & (ss_pg | (~&w & (usr | ctrl_q[CTRL_WP_BIT])));
    end
    e.page_fault = e.err_user_viol | e.err_write_viol;
    e.err_shadow = ss_acc & e.page_fault;
    e.permit = ~(segf | e.page_fault);
    for (int i = 0; i < NUM_BP; i++)
      e.bp_hit[i] = (r.acc_type != ACC_FETCH) && (tag ?
        r.lin_addr[56:0] == bp[i][56:0] : r.lin_addr == bp[i]);
    e.phys_addr = r.phys_addr;
    return e;
  endfunction : model

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid && n < 40);
    if (!s_axi_bvalid) err_count++;
    s_axi_bready <= 1'h0;
    `CHK("bresp", er, s_axi_bresp)
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid && n < 40);
    if (!s_axi_rvalid) err_count++;
    s_axi_rready <= 1'h0;
    `CHK("rresp", er, s_axi_rresp)
    `CHK("rdata", ed, s_axi_rdata)
  endtask : axi_rd

  task automatic set_ctrl(input logic [31:0] v);
    axi_wr(OFF_CTRL, v, RESP_OKAY);
    ctrl_q = v;
  endtask : set_ctrl

  task automatic wbp(input int i, input logic [63:0] v);
    axi_wr(OFF_BP_BASE + 8'(8 * i), v[31:0], RESP_OKAY);
    axi_wr(OFF_BP_BASE + 8'(8 * i + 4), v[63:32], RESP_OKAY);
    bp[i] = v;
  endtask : wbp

  task automatic run(input req_s r);
    resp_s e;
    int n;
    e = model(r);
    n = 0;
    @(posedge sys_clk);
    nreq <= r;
    go <= 1'h1;
    @(posedge sys_clk);
    go <= 1'h0;
    do
      @(posedge sys_clk);
    while (!done && ++n < 10);
    if (!done) err_count++;
    faults += int'(!e.permit);
    `CHK("permit", e.permit, seen.permit)
    `CHK("pf", e.page_fault, seen.page_fault)
    `CHK("gp", e.general_protection_fault, seen.general_protection_fault)
    `CHK("sf", e.stack_fault, seen.stack_fault)
    `CHK("usr", e.err_user_viol, seen.err_user_viol)
    `CHK("wrv", e.err_write_viol, seen.err_write_viol)
    `CHK("ssf", e.err_shadow, seen.err_shadow)
    `CHK("bp", e.bp_hit, seen.bp_hit)
    `CHK("pa", e.phys_addr, seen.phys_addr)
  endtask : run

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out

  initial
  begin
    #(50 * 40000);
    err_count++;
    close_out();
  end

  initial
  begin
    req_s r;
    logic [63:0] a;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'h1;
    void'($urandom(24));
    axi_rd(OFF_CTRL, 32'h0, RESP_OKAY);
    axi_rd(OFF_BP_LAST, 32'h0, RESP_OKAY);
    axi_rd(8'hfc, 32'h0, RESP_SLVERR);
    axi_wr(8'hfc, 32'hffff_ffff, RESP_SLVERR);
    axi_wr(OFF_FAULTS, 32'h1234, RESP_OKAY);
    axi_rd(OFF_FAULTS, 32'h0, RESP_OKAY);
    set_ctrl(32'h0010_001f);
    axi_rd(OFF_CTRL, 32'h0010_001f, RESP_OKAY);
    $display("registers test done");
    for (int c = 0; c < 4; c++)
    begin
      set_ctrl(32'(c));
      for (int p = 0; p < 4; p++)
        for (int u = 0; u < 2; u++)
          for (int t = 0; t < 5; t++)
            for (int k = 0; k < 5; k++)
            begin
              r = '0;
              r.acc_type = acc_type_e'(t);
              r.user_shadow_store_op = u[0];
              r.current_privilege_level = 2'(p);
              r.walk_used = 5'h0f;
              r.walk_user = kuser[k];
              r.walk_write = kwr[k];
              r.final_dirty = kd[k];
              r.lin_addr = 64'h1000;
              r.phys_addr = 52'(k * 4096 + t);
              run(r);
            end
    end
    axi_rd(OFF_FAULTS, 32'(faults), RESP_OKAY);
    $display("shadow stack test done");
    wbp(0, 64'h0000_0000_1234_5000);
    wbp(1, addrs[0]);
    for (int c = 0; c < 16; c++)
    begin
      set_ctrl({11'h0, c[3], 15'h0, c[2:0], 2'h0});
      axi_rd(OFF_STATUS, {31'h0, c[3] & c[1] & c[0]}, RESP_OKAY);
      for (int s = 0; s < 7; s++)
        for (int m = 0; m < 5; m++)
        begin
          r = '0;
          r.acc_type = s[0] ? ACC_READ : ACC_FETCH;
          r.seg = seg_e'(s);
          r.lin_addr = addrs[m % 4];
          r.seg_violation = (m == 4);
          r.seg_is_stack = s[1];
          r.walk_used = 5'h1f;
          r.walk_user = (m == 4) ? 5'h00 : 5'h1f;
          r.walk_write = 5'h1f;
          r.current_privilege_level = PRIV_USER;
          run(r);
        end
    end
    $display("canonical test done");
    wbp(0, {$urandom, $urandom});
    for (int i = 0; i < 400; i++)
    begin
      if (i % 25 == 0) set_ctrl($urandom & 32'h0010_001f);
      a = {$urandom, $urandom};
      case ($urandom % 4)
        0: a = {{16{a[47]}}, a[47:0]};
        1: a = {a[63:57], {9{a[47]}}, a[47:0]};
        2: a = {a[63:57], bp[0][56:0]};
        default: a = a;
      endcase
      r.acc_type = acc_type_e'($urandom % 5);
      r.user_shadow_store_op = 1'($urandom);
      r.current_privilege_level = 2'($urandom);
      r.seg = seg_e'($urandom % 7);
      r.seg_violation = ($urandom % 8 == 0);
      r.seg_is_stack = 1'($urandom);
      r.lin_addr = a;
      r.phys_addr = 52'({$urandom, $urandom});
      r.walk_used = 5'($urandom);
      r.walk_user = 5'($urandom | $urandom);
      r.walk_write = 5'($urandom | $urandom);
      r.final_dirty = 1'($urandom);
      repeat ($urandom % 3) @(posedge sys_clk);
      run(r);
    end
    axi_rd(OFF_FAULTS, 32'(faults), RESP_OKAY);
    $display("random test done");
    close_out();
  end
endmodule : page_access_protection_check_test
